// >>> src/mcr_pkg.sv
// register map and constants of the metering calibration register bank
`default_nettype none

package mcr_pkg;

  localparam int IDX_W    = 15;
  localparam int NUM_REGS = 20;
  localparam int CAL_W    = 24;
  localparam int LEVEL_W  = 28;

  // register indices; byte address is four times the index
  localparam logic [14:0] INTEGRATOR_COEFFICIENT_IDX      = 15'h4388;
  localparam logic [14:0] PHASE_A_POWER_GAIN_IDX          = 15'h4389;
  localparam logic [14:0] PHASE_A_TOTAL_ACTIVE_OFFSET_IDX = 15'h438A;
  localparam logic [14:0] PHASE_B_POWER_GAIN_IDX          = 15'h438B;
  localparam logic [14:0] PHASE_B_TOTAL_ACTIVE_OFFSET_IDX = 15'h438C;
  localparam logic [14:0] PHASE_C_POWER_GAIN_IDX          = 15'h438D;
  localparam logic [14:0] PHASE_C_TOTAL_ACTIVE_OFFSET_IDX = 15'h438E;
  localparam logic [14:0] PHASE_A_CURRENT_RMS_OFFSET_IDX  = 15'h438F;
  localparam logic [14:0] PHASE_A_VOLTAGE_RMS_OFFSET_IDX  = 15'h4390;
  localparam logic [14:0] PHASE_B_CURRENT_RMS_OFFSET_IDX  = 15'h4391;
  localparam logic [14:0] PHASE_B_VOLTAGE_RMS_OFFSET_IDX  = 15'h4392;
  localparam logic [14:0] PHASE_C_CURRENT_RMS_OFFSET_IDX  = 15'h4393;
  localparam logic [14:0] PHASE_C_VOLTAGE_RMS_OFFSET_IDX  = 15'h4394;
  localparam logic [14:0] NEUTRAL_CURRENT_RMS_OFFSET_IDX  = 15'h4395;
  localparam logic [14:0] HARMONIC_POWER_GAIN_IDX         = 15'h4398;
  localparam logic [14:0] CURRENT_SUM_THRESHOLD_IDX       = 15'h4399;
  localparam logic [14:0] FUNDAMENTAL_POWER_LEVEL_IDX     = 15'h439F;
  localparam logic [14:0] PHASE_A_FUND_ACTIVE_OFFSET_IDX  = 15'h43A2;
  localparam logic [14:0] PHASE_B_FUND_ACTIVE_OFFSET_IDX  = 15'h43A3;
  localparam logic [14:0] PHASE_C_FUND_ACTIVE_OFFSET_IDX  = 15'h43A4;
  localparam logic [14:0] CHECK_STATUS_IDX                = 15'h4400;

  // storage slot order
  localparam logic [14:0] SLOT_IDX [NUM_REGS] = '{
    INTEGRATOR_COEFFICIENT_IDX, PHASE_A_POWER_GAIN_IDX, PHASE_A_TOTAL_ACTIVE_OFFSET_IDX,
    PHASE_B_POWER_GAIN_IDX, PHASE_B_TOTAL_ACTIVE_OFFSET_IDX, PHASE_C_POWER_GAIN_IDX,
    PHASE_C_TOTAL_ACTIVE_OFFSET_IDX, PHASE_A_CURRENT_RMS_OFFSET_IDX, PHASE_A_VOLTAGE_RMS_OFFSET_IDX,
    PHASE_B_CURRENT_RMS_OFFSET_IDX, PHASE_B_VOLTAGE_RMS_OFFSET_IDX, PHASE_C_CURRENT_RMS_OFFSET_IDX,
    PHASE_C_VOLTAGE_RMS_OFFSET_IDX, NEUTRAL_CURRENT_RMS_OFFSET_IDX, HARMONIC_POWER_GAIN_IDX,
    CURRENT_SUM_THRESHOLD_IDX, FUNDAMENTAL_POWER_LEVEL_IDX, PHASE_A_FUND_ACTIVE_OFFSET_IDX,
    PHASE_B_FUND_ACTIVE_OFFSET_IDX, PHASE_C_FUND_ACTIVE_OFFSET_IDX};
  localparam int LEVEL_SLOT = 16;

  localparam logic [27:0] CAL_RESET_VAL   = 28'h0000000;
  localparam logic [27:0] LEVEL_RESET_VAL = 28'h0000000;

  // check status fields
  localparam int STAT_LIVE_BIT   = 0;
  localparam int STAT_STICKY_BIT = 1;

endpackage : mcr_pkg

`default_nettype wire

// >>> src/mcr_metering_calibration_regs.sv
// calibration register bank with Avalon-MM slave and current-sum check
`default_nettype none

module mcr_metering_calibration_regs
  import mcr_pkg::*;
#(
  parameter int ADDR_W = 17
) (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic [ADDR_W-1:0]    avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic signed [23:0]   phaseACurrent,
  input  wire logic signed [23:0]   phaseBCurrent,
  input  wire logic signed [23:0]   phaseCCurrent,
  input  wire logic signed [23:0]   neutralCurrent,
  input  wire logic                 sampleValid,
  output logic                      currentSumMismatch,
  output logic signed [23:0]        integratorCoefficient,
  output logic signed [23:0]        phaseAPowerGain,
  output logic signed [23:0]        phaseATotalActiveOffset,
  output logic signed [23:0]        phaseBPowerGain,
  output logic signed [23:0]        phaseBTotalActiveOffset,
  output logic signed [23:0]        phaseCPowerGain,
  output logic signed [23:0]        phaseCTotalActiveOffset,
  output logic signed [23:0]        phaseACurrentRmsOffset,
  output logic signed [23:0]        phaseAVoltageRmsOffset,
  output logic signed [23:0]        phaseBCurrentRmsOffset,
  output logic signed [23:0]        phaseBVoltageRmsOffset,
  output logic signed [23:0]        phaseCCurrentRmsOffset,
  output logic signed [23:0]        phaseCVoltageRmsOffset,
  output logic signed [23:0]        neutralCurrentRmsOffset,
  output logic signed [23:0]        harmonicPowerGain,
  output logic signed [23:0]        currentSumThreshold,
  output logic signed [27:0]        fundamentalPowerLevel,
  output logic signed [23:0]        phaseAFundActiveOffset,
  output logic signed [23:0]        phaseBFundActiveOffset,
  output logic signed [23:0]        phaseCFundActiveOffset
);

  logic [27:0]      cal_reg [NUM_REGS];
  logic             wait_reg;
  logic [31:0]      readData_reg;
  logic             mismatch_reg;
  logic             sticky_reg;
  logic [IDX_W-1:0] regIdx;
  logic             slotHit;
  logic [4:0]       slotNum;
  logic [31:0]      readData_next;
  logic             wrCommit;
  logic             rdTake;
  logic [31:0]      laneMask;
  logic signed [26:0] sumDiff;
  logic [26:0]      absDiff;
  logic signed [27:0] thrExt;
  logic             mismatch_next;

  assign regIdx   = avs_address[ADDR_W-1:2];
  assign wrCommit = avs_write && !wait_reg;
  assign rdTake   = avs_read && wait_reg;
  assign laneMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // slot lookup; reserved gaps and foreign words miss
  always_comb begin
    slotHit = 1'b0;
    slotNum = 5'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (SLOT_IDX[i] == regIdx) begin
        slotHit = 1'b1;
        slotNum = 5'(i);
      end
    end
  end

  // one wait cycle per transfer; the write lands when waitrequest is sampled low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_reg <= 1'b1;
    end else if (!wait_reg) begin
      wait_reg <= 1'b1;
    end else if (avs_read || avs_write) begin
      wait_reg <= 1'b0;
    end
  end

  // calibration storage, byte lanes honoured, bits above the field dropped
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cal_reg[i] <= (i == LEVEL_SLOT) ? LEVEL_RESET_VAL : CAL_RESET_VAL;
      end
    end else if (wrCommit && slotHit) begin
      if (int'(slotNum) == LEVEL_SLOT) begin
        cal_reg[slotNum] <= (cal_reg[slotNum] & ~laneMask[27:0]) | (avs_writedata[27:0] & laneMask[27:0]);
      end else begin
        cal_reg[slotNum] <= {4'h0, (cal_reg[slotNum][23:0] & ~laneMask[23:0])
                                   | (avs_writedata[23:0] & laneMask[23:0])};
      end
    end
  end

  // read formatting: 24-bit fields sign-extended to 28 and zero-padded
  always_comb begin
    readData_next = 32'h00000000;
    if (slotHit && int'(slotNum) == LEVEL_SLOT) begin
      readData_next = {4'h0, cal_reg[slotNum]};
    end else if (slotHit) begin
      readData_next = {4'h0, {4{cal_reg[slotNum][23]}}, cal_reg[slotNum][23:0]};
    end else if (regIdx == CHECK_STATUS_IDX) begin
      readData_next[STAT_LIVE_BIT]   = mismatch_reg;
      readData_next[STAT_STICKY_BIT] = sticky_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      readData_reg <= 32'h00000000;
    end else if (rdTake) begin
      readData_reg <= readData_next;
    end
  end

  // current-sum check against the programmed threshold
  always_comb begin
    sumDiff       = 27'(phaseACurrent) + 27'(phaseBCurrent) + 27'(phaseCCurrent) - 27'(neutralCurrent);
    absDiff       = sumDiff[26] ? 27'(-sumDiff) : 27'(sumDiff);
    thrExt        = 28'(signed'(cal_reg[15][23:0]));
    mismatch_next = $signed({1'b0, absDiff}) > thrExt;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mismatch_reg <= 1'b0;
    end else if (sampleValid) begin
      mismatch_reg <= mismatch_next;
    end
  end

  // sticky flag, write one to clear, a new event wins over the clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sticky_reg <= 1'b0;
    end else if (sampleValid && mismatch_next) begin
      sticky_reg <= 1'b1;
    end else if (wrCommit && regIdx == CHECK_STATUS_IDX && avs_byteenable[0]
                 && avs_writedata[STAT_STICKY_BIT]) begin
      sticky_reg <= 1'b0;
    end
  end

  assign avs_readdata            = readData_reg;
  assign avs_waitrequest         = wait_reg;
  assign currentSumMismatch      = mismatch_reg;
  assign integratorCoefficient   = cal_reg[0][23:0];
  assign phaseAPowerGain         = cal_reg[1][23:0];
  assign phaseATotalActiveOffset = cal_reg[2][23:0];
  assign phaseBPowerGain         = cal_reg[3][23:0];
  assign phaseBTotalActiveOffset = cal_reg[4][23:0];
  assign phaseCPowerGain         = cal_reg[5][23:0];
  assign phaseCTotalActiveOffset = cal_reg[6][23:0];
  assign phaseACurrentRmsOffset  = cal_reg[7][23:0];
  assign phaseAVoltageRmsOffset  = cal_reg[8][23:0];
  assign phaseBCurrentRmsOffset  = cal_reg[9][23:0];
  assign phaseBVoltageRmsOffset  = cal_reg[10][23:0];
  assign phaseCCurrentRmsOffset  = cal_reg[11][23:0];
  assign phaseCVoltageRmsOffset  = cal_reg[12][23:0];
  assign neutralCurrentRmsOffset = cal_reg[13][23:0];
  assign harmonicPowerGain       = cal_reg[14][23:0];
  assign currentSumThreshold     = cal_reg[15][23:0];
  assign fundamentalPowerLevel   = cal_reg[LEVEL_SLOT];
  assign phaseAFundActiveOffset  = cal_reg[17][23:0];
  assign phaseBFundActiveOffset  = cal_reg[18][23:0];
  assign phaseCFundActiveOffset  = cal_reg[19][23:0];

  // separate reckoning of the current-sum decision for the checks below
  logic signed [27:0] chkSum;
  logic               chkOver;

  assign chkSum  = 28'(phaseACurrent) + 28'(phaseBCurrent) + 28'(phaseCCurrent) - 28'(neutralCurrent);
  assign chkOver = (chkSum > 28'(currentSumThreshold)) || (-chkSum > 28'(currentSumThreshold));

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  property p_gain_reset;
    $fell(srst) |-> (phaseAPowerGain == 24'sh000000) && (phaseBPowerGain == 24'sh000000)
             && (phaseCPowerGain == 24'sh000000);
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("power gain not zero after reset");

  property p_total_offset_write;
    wrCommit && regIdx == PHASE_B_TOTAL_ACTIVE_OFFSET_IDX && avs_byteenable == 4'hF
      |=> $unsigned(phaseBTotalActiveOffset) == $past(avs_writedata[23:0]);
  endproperty
  a_total_offset_write: assert property (p_total_offset_write) else $error("total offset write lost");

  property p_coef_read_format;
    rdTake && regIdx == INTEGRATOR_COEFFICIENT_IDX
      |=> !avs_waitrequest && avs_readdata == {4'h0, {4{$past(cal_reg[0][23])}}, $past(cal_reg[0][23:0])};
  endproperty
  a_coef_read_format: assert property (p_coef_read_format) else $error("coefficient read not sign-extended");

  property p_sum_check;
    sampleValid |=> currentSumMismatch == $past(chkOver);
  endproperty
  a_sum_check: assert property (p_sum_check) else $error("current sum check wrong");

  property p_rms_reset;
    $fell(srst) |-> (phaseACurrentRmsOffset == 24'sh000000) && (phaseCVoltageRmsOffset == 24'sh000000)
             && (neutralCurrentRmsOffset == 24'sh000000);
  endproperty
  a_rms_reset: assert property (p_rms_reset) else $error("rms offset not zero after reset");

  property p_harmonic_gain_write;
    wrCommit && regIdx == HARMONIC_POWER_GAIN_IDX && avs_byteenable == 4'hF
      |=> $unsigned(harmonicPowerGain) == $past(avs_writedata[23:0]) ##1 $stable(harmonicPowerGain);
  endproperty
  a_harmonic_gain_write: assert property (p_harmonic_gain_write) else $error("harmonic gain write lost");

  property p_fund_offset_apart;
    wrCommit && regIdx == PHASE_A_FUND_ACTIVE_OFFSET_IDX
      |=> $stable(phaseATotalActiveOffset) && ($unsigned(phaseAFundActiveOffset)
          == (($past(cal_reg[17][23:0]) & ~$past(laneMask[23:0])) | ($past(avs_writedata[23:0]) & $past(laneMask[23:0]))));
  endproperty
  a_fund_offset_apart: assert property (p_fund_offset_apart) else $error("fundamental offset not separate");

  property p_signed_read;
    rdTake && slotHit && int'(slotNum) != LEVEL_SLOT
      |=> avs_readdata[31:28] == 4'h0 && avs_readdata[27:24] == {4{avs_readdata[23]}};
  endproperty
  a_signed_read: assert property (p_signed_read) else $error("signed read padding wrong");

  property p_wait_bound;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("waitrequest timing wrong");

  property p_sticky_hold;
    sticky_reg && !(wrCommit && regIdx == CHECK_STATUS_IDX) |=> sticky_reg;
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag dropped");

  property p_sticky_set_wins;
    sampleValid && chkOver |=> sticky_reg;
  endproperty
  a_sticky_set_wins: assert property (p_sticky_set_wins) else $error("sticky flag missed a mismatch");

  property p_status_read;
    rdTake && regIdx == CHECK_STATUS_IDX
      |=> avs_readdata == {30'h0, $past(sticky_reg), $past(currentSumMismatch)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_wait_idle;
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest dropped without a request");

  property p_level_write;
    wrCommit && regIdx == FUNDAMENTAL_POWER_LEVEL_IDX && avs_byteenable == 4'hF
      |=> $unsigned(fundamentalPowerLevel) == $past(avs_writedata[27:0]);
  endproperty
  a_level_write: assert property (p_level_write) else $error("level write lost");

  property p_unmapped_write_ignored;
    wrCommit && !slotHit
      |=> $stable(phaseAPowerGain) && $stable(currentSumThreshold) && $stable(fundamentalPowerLevel);
  endproperty
  a_unmapped_write_ignored: assert property (p_unmapped_write_ignored) else $error("unmapped write changed a register");

  c_coef_write:   cover property (wrCommit && regIdx == INTEGRATOR_COEFFICIENT_IDX
                                  && avs_writedata == 32'h0FFF8000);
  c_level_read:   cover property (rdTake && regIdx == FUNDAMENTAL_POWER_LEVEL_IDX);
  c_mismatch:     cover property (sampleValid && mismatch_next);
  c_set_vs_clear: cover property (sampleValid && mismatch_next && wrCommit && regIdx == CHECK_STATUS_IDX);

endmodule : mcr_metering_calibration_regs

`default_nettype wire

// >>> verif/mcr_host_model.sv
// host bus master model for the calibration bank
`default_nettype none

module mcr_host_model (
  input  wire logic        core_clk,
  output var  logic [16:0] avs_address,
  output var  logic        avs_read,
  output var  logic        avs_write,
  output var  logic [31:0] avs_writedata,
  output var  logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    avs_address = 17'h00000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
  end

  // request held until waitrequest sampled low
  task automatic access(input logic wr, input logic [14:0] idx, input logic [31:0] wdata,
                        input logic [3:0] be, output logic [31:0] rdata);
    rdata = 32'h00000000;
    if (wr && idx inside {[15'h4396:15'h4397], [15'h439A:15'h439E], [15'h43A0:15'h43A1]}) return;
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wdata;
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~{idx, 2'b00};
    avs_writedata <= ~wdata;
  endtask : access

endmodule : mcr_host_model

`default_nettype wire

// >>> verif/tb_metering_calibration_regs.sv
// bench of the calibration bank against an integer model
`default_nettype none

module tb_metering_calibration_regs;
  import mcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic               core_clk = 1'b0;
  logic               srst = 1'b1;
  wire logic [16:0]   avs_address;
  wire logic          avs_read;
  wire logic          avs_write;
  wire logic [31:0]   avs_writedata;
  wire logic [3:0]    avs_byteenable;
  wire logic [31:0]   avs_readdata;
  wire logic          avs_waitrequest;
  logic signed [23:0] cur [4] = '{default: 24'h000000};
  logic               sampleValid = 1'b0;
  wire logic          currentSumMismatch;
  wire logic [23:0]   calOut [NUM_REGS];
  wire logic [27:0]   levelOut;
  int                 mdl [NUM_REGS] = '{default: 0};
  int                 failCount = 0;
  int                 comparisons = 0;
  bit                 stickyMdl = 1'b0;
  bit                 liveMdl = 1'b0;
  logic [14:0]        rsv [4] = '{15'h4396, 15'h439A, 15'h439E, 15'h43A1};

  always #5 core_clk = ~core_clk;

  mcr_host_model mcr_host_model_inst (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  mcr_metering_calibration_regs mcr_metering_calibration_regs_inst (.core_clk(core_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .phaseACurrent(cur[0]), .phaseBCurrent(cur[1]), .phaseCCurrent(cur[2]), .neutralCurrent(cur[3]),
    .sampleValid(sampleValid), .currentSumMismatch(currentSumMismatch),
    .integratorCoefficient(calOut[0]), .phaseAPowerGain(calOut[1]), .phaseATotalActiveOffset(calOut[2]),
    .phaseBPowerGain(calOut[3]), .phaseBTotalActiveOffset(calOut[4]), .phaseCPowerGain(calOut[5]),
    .phaseCTotalActiveOffset(calOut[6]), .phaseACurrentRmsOffset(calOut[7]),
    .phaseAVoltageRmsOffset(calOut[8]), .phaseBCurrentRmsOffset(calOut[9]),
    .phaseBVoltageRmsOffset(calOut[10]), .phaseCCurrentRmsOffset(calOut[11]),
    .phaseCVoltageRmsOffset(calOut[12]), .neutralCurrentRmsOffset(calOut[13]),
    .harmonicPowerGain(calOut[14]), .currentSumThreshold(calOut[15]), .fundamentalPowerLevel(levelOut),
    .phaseAFundActiveOffset(calOut[17]), .phaseBFundActiveOffset(calOut[18]),
    .phaseCFundActiveOffset(calOut[19]));

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      failCount++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, expv);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  function automatic logic [31:0] expRead(input int s);
    if (s == LEVEL_SLOT) return {4'h0, mdl[s][27:0]};
    return {4'h0, {4{mdl[s][23]}}, mdl[s][23:0]};
  endfunction : expRead

  function automatic logic [31:0] portVal(input int s);
    return (s == LEVEL_SLOT) ? {4'h0, levelOut} : {8'h00, calOut[s]};
  endfunction : portVal

  task automatic busRead(input logic [14:0] idx, input logic [31:0] expv);
    logic [31:0] r;
    mcr_host_model_inst.access(1'b0, idx, 32'h00000000, 4'h0, r);
    check(r, expv);
  endtask : busRead

  task automatic slotWrite(input int s, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = mdl[s];
    for (int b = 0; b < 4; b++)
      if (be[b]) m[8*b +: 8] = d[8*b +: 8];
    mdl[s] = int'(m & ((s == LEVEL_SLOT) ? 32'h0FFFFFFF : 32'h00FFFFFF));
    mcr_host_model_inst.access(1'b1, SLOT_IDX[s], d, be, m);
    #1;
    check(portVal(s), 32'(mdl[s]));
  endtask : slotWrite

  task automatic sample(input int a, input int b, input int c, input int n);
    int diff;
    @(posedge core_clk);
    cur <= '{24'(a), 24'(b), 24'(c), 24'(n)};
    sampleValid <= 1'b1;
    @(posedge core_clk);
    sampleValid <= 1'b0;
    #1;
    diff = (a + b + c - n < 0) ? n - a - b - c : a + b + c - n;
    liveMdl = diff > int'($signed(mdl[15][23:0]));
    stickyMdl |= liveMdl;
    check({31'h0, currentSumMismatch}, {31'h0, liveMdl});
  endtask : sample

  initial begin
    repeat (50000) @(posedge core_clk);
    failCount++;
    conclude();
  end

  initial begin
    void'($urandom(61));
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    for (int s = 0; s < NUM_REGS; s++) begin
      busRead(SLOT_IDX[s], 32'h00000000);
      check(portVal(s), 32'h00000000);
    end
    $display("test reset values done");
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < NUM_REGS; s++)
        slotWrite(s, $urandom(), p ? 4'($urandom()) : 4'hF);
      for (int s = 0; s < NUM_REGS; s++)
        busRead(SLOT_IDX[s], expRead(s));
    end
    foreach (rsv[i]) busRead(rsv[i], 32'h00000000);
    slotWrite(0, 32'h0FFF8000, 4'hF);
    busRead(INTEGRATOR_COEFFICIENT_IDX, 32'h0FFF8000);
    slotWrite(LEVEL_SLOT, 32'h0ABCDEF1, 4'hF);
    $display("test readback done");
    slotWrite(15, 32'h000003E8, 4'hF);
    sample(1000, 0, 0, 0);
    sample(0, 0, 0, 1001);
    busWrite_clear();
    for (int i = 0; i < 40; i++)
      sample(int'($urandom_range(1200)) - 600, int'($urandom_range(1200)) - 600,
             int'($urandom_range(1200)) - 600, int'($urandom_range(1200)) - 600);
    busRead(CHECK_STATUS_IDX, {30'h0, stickyMdl, liveMdl});
    slotWrite(15, 32'h00FFFFFF, 4'hF);
    sample(0, 0, 0, 0);
    $display("test current sum done");
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    mdl = '{default: 0};
    #1;
    for (int s = 0; s < NUM_REGS; s++)
      check(portVal(s), 32'h00000000);
    check({31'h0, currentSumMismatch}, 32'h00000000);
    busRead(PHASE_A_POWER_GAIN_IDX, 32'h00000000);
    busRead(CHECK_STATUS_IDX, 32'h00000000);
    $display("test second reset done");
    conclude();
  end

  // sticky clear, then status shows live bit only
  task automatic busWrite_clear();
    logic [31:0] r;
    busRead(CHECK_STATUS_IDX, {30'h0, stickyMdl, liveMdl});
    mcr_host_model_inst.access(1'b1, CHECK_STATUS_IDX, 32'h00000002, 4'h1, r);
    stickyMdl = 1'b0;
    busRead(CHECK_STATUS_IDX, {30'h0, stickyMdl, liveMdl});
  endtask : busWrite_clear

endmodule : tb_metering_calibration_regs

`default_nettype wire
